// ==== src/tse_monitor.sv ====
// Tolerance sorting, switching outputs and error supervision with register port
`default_nettype none

module tse_monitor
  import tse_pkg::*;
#(
  parameter int unsigned VAL_W      = 40,             // Width of incoming position value
  parameter longint      DISP_RANGE = 999_999_999,    // Largest magnitude the display shows
  parameter int unsigned REQ_GAP_NS = 10_000          // Least spacing of output requests
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  // Register port
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire logic [DATA_W-1:0]       wdata,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic      [DATA_W-1:0]       rdata,
  // Measurement path
  input  wire logic signed [VAL_W-1:0] disp_value,
  input  wire logic                    disp_valid,
  input  wire logic                    meas_req,
  input  wire tse_err_evt_t            err_evt,
  // Operator and switching connector
  input  wire logic                    cancel_key,
  input  wire logic                    ext_ack_pin,
  output logic                         below_out,
  output logic                         above_out,
  output logic                         error_out,
  // Indications
  output tse_sort_t                    sym,
  output tse_colour_t                  colour,
  output logic                         err_shown_valid,
  output logic      [CAT_W-1:0]        err_shown_code,
  output logic                         ctrl_chart_view
);

  // Request spacing as whole cycles, rounded up
  localparam int unsigned GAP_CYC = (REQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_W   = $clog2(GAP_CYC + 1);

  // Refuse widths the compare cannot serve
  initial begin
    if (VAL_W < DATA_W || VAL_W > 64 || GAP_CYC < 1 || DISP_RANGE < 1) begin
      $error("tse_monitor: unsupported parameter values");
    end
  end

  // Whole state of the block
  typedef struct packed {
    logic               sort_en;     // Sorting switched on
    logic               colour_rg;   // Red/green colouring selected
    logic [DATA_W-1:0]  lower;       // Lower sorting limit
    logic [DATA_W-1:0]  upper;       // Upper sorting limit
    tse_sort_t          sym;         // Lit symbols
    tse_colour_t        colour;      // Display colour
    logic               below;       // Below-limit output
    logic               above;       // Above-limit output
    logic               err_out;     // Error output
    logic               chart;       // Control chart shown
    logic               shown_valid; // An error is on screen
    logic [CAT_W-1:0]   shown_code;  // Category on screen
    logic [DATA_W-1:0]  rdata;       // Read answer
    logic [1:0]         ack_sync;    // External acknowledge synchroniser
    logic               ack_prev;    // Synchronised level one cycle back
    logic [1:0]         pos_prev;    // Encoder error bits one cycle back
    logic [GAP_W-1:0]   gap_cnt;     // Cycles since last output request
    logic               gap_seen;    // A request has been seen
  } mon_state_t;

  mon_state_t s_q;    // Registered state
  mon_state_t s_d;    // Next state

  // Error store connections
  logic [NUM_CAT-1:0] raise;      // Category raised this cycle
  logic               ack;        // Acknowledge the shown error
  logic [NUM_CAT-1:0] pending;    // Pending categories
  logic               stk_valid;  // Store holds an error
  logic [CAT_W-1:0]   stk_idx;    // Newest pending category

  // Value handling
  logic signed [DATA_W-1:0] disp_word;  // Value cut to display width
  logic                     overflow;   // Value beyond display range
  logic                     rate_err;   // Requests too close

  // Signed compare of value against one limit
  function automatic logic sgn_less(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    return $signed(a) < $signed(b);
  endfunction

  // Classify one value; an inverted window lights all symbols
  function automatic tse_sort_t classify(input logic [DATA_W-1:0] v,
                                         input logic [DATA_W-1:0] lo,
                                         input logic [DATA_W-1:0] hi);
    tse_sort_t r;
    r = '0;
    if (sgn_less(hi, lo)) begin
      r = '{lt: 1'b1, eq: 1'b1, gt: 1'b1};
    end else if (sgn_less(v, lo)) begin
      r.lt = 1'b1;
    end else if (sgn_less(hi, v)) begin
      r.gt = 1'b1;
    end else begin
      r.eq = 1'b1;
    end
    return r;
  endfunction

  // Per-category error store
  tse_err_stack #(
    .NUM   (NUM_CAT),
    .SEQ_W (16)
  ) u_stack (
    .clk         (clk),
    .reset       (reset),
    .raise       (raise),
    .ack         (ack),
    .pending     (pending),
    .shown_valid (stk_valid),
    .shown_idx   (stk_idx)
  );

  // Display range check and cut to display width
  always_comb begin
    disp_word = disp_value[DATA_W-1:0];
    overflow  = disp_valid &&
                ((64'(disp_value) > DISP_RANGE) || (64'(disp_value) < -DISP_RANGE));
  end

  // Request spacing check
  always_comb begin
    rate_err = meas_req && s_q.gap_seen && (32'(s_q.gap_cnt) < GAP_CYC);
  end

  // Gather fault events into categories
  always_comb begin
    raise                  = '0;
    raise[CAT_REF_SPACING] = err_evt.ref_spacing;
    raise[CAT_DSR_MISSING] = err_evt.dsr_missing;
    raise[CAT_LINK_FAULT]  = err_evt.link_fault;
    raise[CAT_FREQ_HIGH_1] = err_evt.freq_high[0];
    raise[CAT_FREQ_HIGH_2] = err_evt.freq_high[1];
    raise[CAT_OVERFLOW]    = overflow;
    // Error bit is a level; only its rising edge raises again
    raise[CAT_POS_ERR_1]   = err_evt.pos_err[0] && !s_q.pos_prev[0];
    raise[CAT_POS_ERR_2]   = err_evt.pos_err[1] && !s_q.pos_prev[1];
    raise[CAT_AMP_SMALL_1] = err_evt.amp_small[0];
    raise[CAT_AMP_SMALL_2] = err_evt.amp_small[1];
    raise[CAT_AMP_LARGE_1] = err_evt.amp_large[0];
    raise[CAT_AMP_LARGE_2] = err_evt.amp_large[1];
    raise[CAT_CMD_RATE]    = rate_err;
    raise[CAT_CTRL_LIMIT]  = err_evt.ctrl_limit;
  end

  // Acknowledge from key, register write or rising external level
  always_comb begin
    ack = cancel_key ||
          (wr_en && addr == REG_ACK) ||
          (s_q.ack_sync[1] && !s_q.ack_prev);
  end

  // Next-state logic
  always_comb begin
    s_d = s_q;

    // External acknowledge passes two flip-flops first
    s_d.ack_sync = {s_q.ack_sync[0], ext_ack_pin};
    s_d.ack_prev = s_q.ack_sync[1];
    s_d.pos_prev = err_evt.pos_err;

    // Request spacing counter saturates at the least gap
    if (meas_req) begin
      s_d.gap_cnt  = '0;
      s_d.gap_seen = 1'b1;
    end else if (32'(s_q.gap_cnt) < GAP_CYC) begin
      s_d.gap_cnt = s_q.gap_cnt + GAP_W'(1);
    end

    // Register writes
    if (wr_en) begin
      unique case (addr)
        REG_CTRL: begin
          s_d.sort_en   = wdata[CTRL_EN_BIT];
          s_d.colour_rg = wdata[CTRL_RG_BIT];
        end
        REG_LOWER: begin
          s_d.lower = wdata;
        end
        REG_UPPER: begin
          s_d.upper = wdata;
        end
        default: begin
          // Read-only, acknowledge or unmapped: nothing stored
        end
      endcase
    end

    // Sorting result, outputs and indication move together
    if (!s_q.sort_en) begin
      s_d.sym    = '0;
      s_d.below  = 1'b0;
      s_d.above  = 1'b0;
      s_d.colour = COL_BLUE;
    end else if (disp_valid && !overflow) begin
      s_d.sym    = classify(disp_word, s_q.lower, s_q.upper);
      s_d.below  = sgn_less(disp_word, s_q.lower);
      s_d.above  = sgn_less(s_q.upper, disp_word);
      if (!s_q.colour_rg) begin
        s_d.colour = COL_BLUE;
      end else if (s_d.sym == '{lt: 1'b0, eq: 1'b1, gt: 1'b0}) begin
        s_d.colour = COL_GREEN;
      end else begin
        s_d.colour = COL_RED;
      end
    end

    // Error output follows pending spacing, link, frequency and large-amplitude categories only
    s_d.err_out = |(pending & ENC_ERR_MASK);

    // Control chart view held while its warning is pending
    s_d.chart = pending[CAT_CTRL_LIMIT];

    // Newest pending error on screen
    s_d.shown_valid = stk_valid;
    s_d.shown_code  = stk_valid ? stk_idx : '0;

    // Read answer stands only in the cycle after the strobe
    s_d.rdata = '0;
    if (rd_en) begin
      unique case (addr)
        REG_CTRL: begin
          s_d.rdata[CTRL_EN_BIT] = s_q.sort_en;
          s_d.rdata[CTRL_RG_BIT] = s_q.colour_rg;
        end
        REG_LOWER: begin
          s_d.rdata = s_q.lower;
        end
        REG_UPPER: begin
          s_d.rdata = s_q.upper;
        end
        REG_ERRS: begin
          s_d.rdata[NUM_CAT-1:0] = pending;
        end
        REG_SHOWN: begin
          s_d.rdata[SHOWN_CODE_LSB +: CAT_W] = s_q.shown_code;
          s_d.rdata[SHOWN_VALID_BIT]         = s_q.shown_valid;
          s_d.rdata[SHOWN_LT_BIT]            = s_q.sym.lt;
          s_d.rdata[SHOWN_EQ_BIT]            = s_q.sym.eq;
          s_d.rdata[SHOWN_GT_BIT]            = s_q.sym.gt;
          s_d.rdata[SHOWN_CHART_BIT]         = s_q.chart;
        end
        default: begin
          // Unmapped and write-only addresses read as zero
        end
      endcase
    end
  end

  // State register with defined reset values
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q           <= '0;
      s_q.sort_en   <= CTRL_EN_RESET;
      s_q.colour_rg <= CTRL_RG_RESET;
      s_q.lower     <= LIMIT_RESET;
      s_q.upper     <= LIMIT_RESET;
      s_q.colour    <= COL_BLUE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flip-flops
  assign rdata           = s_q.rdata;
  assign below_out       = s_q.below;
  assign above_out       = s_q.above;
  assign error_out       = s_q.err_out;
  assign sym             = s_q.sym;
  assign colour          = s_q.colour;
  assign err_shown_valid = s_q.shown_valid;
  assign err_shown_code  = s_q.shown_code;
  assign ctrl_chart_view = s_q.chart;

endmodule

`default_nettype wire

// ==== src/tse_pkg.sv ====
// Shared constants, types and register map of the tolerance sorting and error monitor
// Operation
// - Value between limits: within, green equal symbol
// - Below or above limits: red less/greater symbol
// - Below-limit output active when value under lower
// - Above-limit output active when value over upper
// - Outputs and indication change in same cycle
// - Exactly one class; limits shared with statistics
// - Software switch turns sorting on or off
// - Colour mode red/green or blue, blue default
// - Upper below lower lights every symbol
// - Keep only last error per category
// - Cancel key or external input acknowledges error
// - Newest pending error is shown first
// - After acknowledge, show previous pending error
// - Error output for encoder-related fault categories; not for small amplitude or position error
// - Control-limit warning switches chart, no error output
// - Output requests too close raise rate error
// - Value beyond display range raises overflow error
// - Small amplitude per input raises error
// - Missing ready indication raises error
// - Encoder error bit raises per-axis position error
`default_nettype none

package tse_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;  // Sorting enable and colour mode
  localparam logic [ADDR_W-1:0] REG_LOWER  = 8'h04;  // Lower sorting limit, signed
  localparam logic [ADDR_W-1:0] REG_UPPER  = 8'h08;  // Upper sorting limit, signed
  localparam logic [ADDR_W-1:0] REG_ERRS   = 8'h0c;  // Pending error categories, read only
  localparam logic [ADDR_W-1:0] REG_SHOWN  = 8'h10;  // Shown error and sort state, read only
  localparam logic [ADDR_W-1:0] REG_ACK    = 8'h14;  // Write acknowledges the shown error

  // Control field positions and reset values
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_RG_BIT    = 1;
  localparam logic        CTRL_EN_RESET  = 1'b0;
  localparam logic        CTRL_RG_RESET  = 1'b0;    // Blue after reset
  localparam logic [DATA_W-1:0] LIMIT_RESET = 32'h0000_0000;

  // Shown register field positions
  localparam int unsigned SHOWN_CODE_LSB  = 0;
  localparam int unsigned SHOWN_VALID_BIT = 8;
  localparam int unsigned SHOWN_LT_BIT    = 16;
  localparam int unsigned SHOWN_EQ_BIT    = 17;
  localparam int unsigned SHOWN_GT_BIT    = 18;
  localparam int unsigned SHOWN_CHART_BIT = 24;

  // Clock period used to turn times into cycles
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Error categories, one slot each
  localparam int unsigned NUM_CAT = 14;
  localparam int unsigned CAT_W   = 4;
  typedef enum logic [CAT_W-1:0] {
    CAT_REF_SPACING,
    CAT_DSR_MISSING,
    CAT_LINK_FAULT,
    CAT_FREQ_HIGH_1,
    CAT_FREQ_HIGH_2,
    CAT_OVERFLOW,
    CAT_POS_ERR_1,
    CAT_POS_ERR_2,
    CAT_AMP_SMALL_1,
    CAT_AMP_SMALL_2,
    CAT_AMP_LARGE_1,
    CAT_AMP_LARGE_2,
    CAT_CMD_RATE,
    CAT_CTRL_LIMIT
  } tse_cat_t;

  // Categories that drive the error output: spacing, link, frequency, large amplitude
  localparam logic [NUM_CAT-1:0] ENC_ERR_MASK = 14'h0c1d;

  // Fault events from the measurement path, same clock
  typedef struct packed {
    logic       ref_spacing;   // Reference mark spacing mismatch, pulse
    logic       dsr_missing;   // Ready indication absent, pulse
    logic       link_fault;    // Encoder link communication fault, pulse
    logic [1:0] freq_high;     // Input frequency too high per input, pulse
    logic [1:0] amp_small;     // Amplitude too small per input, pulse
    logic [1:0] amp_large;     // Amplitude too large per input, pulse
    logic [1:0] pos_err;       // Encoder internal error bit per axis, level
    logic       ctrl_limit;    // Control limit violated, pulse
  } tse_err_evt_t;

  // Sorting symbols
  typedef struct packed {
    logic lt;
    logic eq;
    logic gt;
  } tse_sort_t;

  // Display value colour
  typedef enum logic [1:0] {
    COL_BLUE,
    COL_GREEN,
    COL_RED
  } tse_colour_t;

endpackage

`default_nettype wire

// ==== src/tse_err_stack.sv ====
// Per-category error store that presents the newest unacknowledged error
`default_nettype none

module tse_err_stack
  import tse_pkg::*;
#(
  parameter int unsigned NUM   = NUM_CAT,
  parameter int unsigned SEQ_W = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [NUM-1:0]   raise,
  input  wire logic             ack,
  output logic      [NUM-1:0]   pending,
  output logic                  shown_valid,
  output logic      [CAT_W-1:0] shown_idx
);

  // Refuse sizes the index field cannot address
  initial begin
    if (NUM > (1 << CAT_W) || NUM == 0 || SEQ_W < 2) begin
      $error("tse_err_stack: unsupported NUM or SEQ_W");
    end
  end

  // Whole state: pending flags, age stamps, next stamp
  typedef struct packed {
    logic [NUM-1:0]            pend;
    logic [NUM-1:0][SEQ_W-1:0] stamp;
    logic [SEQ_W-1:0]          next_seq;
  } stk_state_t;

  stk_state_t s_q;    // Registered state
  stk_state_t s_d;    // Next state
  logic             found;   // Some error pending
  logic [CAT_W-1:0] best;    // Newest pending slot

  // Pick the newest pending slot; ties go to the higher slot
  always_comb begin
    found = 1'b0;
    best  = '0;
    for (int i = 0; i < NUM; i++) begin
      if (s_q.pend[i] && (!found || s_q.stamp[i] >= s_q.stamp[best])) begin
        found = 1'b1;
        best  = CAT_W'(i);
      end
    end
  end

  // Acknowledge first, then new errors, so a raise wins over a clear
  always_comb begin
    s_d = s_q;
    if (ack && found) begin
      s_d.pend[best] = 1'b0;
    end
    for (int i = 0; i < NUM; i++) begin
      if (raise[i]) begin
        s_d.pend[i]  = 1'b1;
        s_d.stamp[i] = s_q.next_seq;
      end
    end
    // Restart the age count once nothing is pending; saturate otherwise
    if (raise != '0) begin
      if (s_q.next_seq != '1) begin
        s_d.next_seq = s_q.next_seq + SEQ_W'(1);
      end
    end else if (s_d.pend == '0) begin
      s_d.next_seq = '0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pending     = s_q.pend;
  assign shown_valid = found;
  assign shown_idx   = best;

endmodule

`default_nettype wire

// ==== verif/tse_monitor_props.sv ====
// Concurrent checks on the ports of the tolerance sorting and error monitor
`default_nettype none

module tse_monitor_props
  import tse_pkg::*;
#(
  parameter int unsigned VAL_W      = 40,
  parameter longint      DISP_RANGE = 999_999_999
) (
  input wire logic                    clk,
  input wire logic                    reset,
  input wire logic [ADDR_W-1:0]       addr,
  input wire logic [DATA_W-1:0]       wdata,
  input wire logic                    wr_en,
  input wire logic                    rd_en,
  input wire logic [DATA_W-1:0]       rdata,
  input wire logic signed [VAL_W-1:0] disp_value,
  input wire logic                    disp_valid,
  input wire logic                    meas_req,
  input wire tse_err_evt_t            err_evt,
  input wire logic                    cancel_key,
  input wire logic                    ext_ack_pin,
  input wire logic                    below_out,
  input wire logic                    above_out,
  input wire logic                    error_out,
  input wire tse_sort_t               sym,
  input wire tse_colour_t             colour,
  input wire logic                    err_shown_valid,
  input wire logic [CAT_W-1:0]        err_shown_code,
  input wire logic                    ctrl_chart_view
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam tse_err_evt_t DSR_ONLY = '{dsr_missing: 1'b1, default: '0};
  logic               en_q;   // Shadow of the sorting enable
  logic               rg_q;   // Shadow of the colour mode
  logic signed [31:0] lo_q;   // Shadow of the lower limit
  logic signed [31:0] hi_q;   // Shadow of the upper limit
  logic signed [31:0] v32;    // Compared part of the value
  logic               inr;    // Value inside the display range
  logic               quiet;  // No key or register acknowledge and no other raise source
  assign v32 = disp_value[31:0];
  assign inr = (disp_value <= DISP_RANGE) && (disp_value >= -DISP_RANGE);
  assign quiet = !cancel_key && !(wr_en && addr == REG_ACK) && !disp_valid && !meas_req;
  // Mirrors the control and limit registers from bus writes
  always_ff @(posedge clk) begin
    if (reset) begin
      en_q <= 1'b0;
      rg_q <= 1'b0;
      lo_q <= '0;
      hi_q <= '0;
    end else if (wr_en) begin
      if (addr == REG_CTRL) begin
        en_q <= wdata[CTRL_EN_BIT];
        rg_q <= wdata[CTRL_RG_BIT];
      end
      if (addr == REG_LOWER) lo_q <= wdata;
      if (addr == REG_UPPER) hi_q <= wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_sort_ok;
    disp_valid && en_q && inr && (lo_q <= hi_q);
  endsequence
  sequence s_dsr_only;
    (err_evt == DSR_ONLY && quiet) ##1 (err_evt == '0 && quiet) ##1 quiet;
  endsequence
  a_below_sort: assert property (s_sort_ok and (v32 < lo_q) |=> below_out && !above_out && sym == 3'b100
    && colour == (rg_q ? COL_RED : COL_BLUE)) else $error("below class wrong");
  a_above_sort: assert property (s_sort_ok and (v32 > hi_q) |=> above_out && !below_out && sym == 3'b001
    && colour == (rg_q ? COL_RED : COL_BLUE)) else $error("above class wrong");
  a_within_sort: assert property (s_sort_ok and (v32 >= lo_q && v32 <= hi_q) |=> sym == 3'b010
    && !below_out && !above_out && colour == (rg_q ? COL_GREEN : COL_BLUE)) else $error("within class wrong");
  a_outs_agree: assert property (sym != 3'b111 |-> below_out == (sym == 3'b100) && above_out == (sym == 3'b001))
    else $error("outputs disagree with symbols");
  a_class_shape: assert property ($onehot0(sym) || sym == 3'b111) else $error("more than one class lit");
  a_green_within: assert property (colour == COL_GREEN |-> sym == 3'b010) else $error("green without equal");
  a_red_class: assert property (colour == COL_RED |-> sym.lt || sym.gt) else $error("red without bound symbol");
  a_disable_clear: assert property (wr_en && addr == REG_CTRL && !wdata[CTRL_EN_BIT] |-> ##[1:3]
    (sym == 3'b000 && !below_out && !above_out && colour == COL_BLUE)) else $error("disable left outputs on");
  a_newest_shown: assert property (s_dsr_only |-> err_shown_valid && err_shown_code == CAT_DSR_MISSING)
    else $error("newest error not shown");
  a_errout_shown: assert property (err_shown_valid && ENC_ERR_MASK[err_shown_code] |-> error_out)
    else $error("encoder error without error output");
  a_chart_view: assert property (err_shown_valid && err_shown_code == CAT_CTRL_LIMIT |-> ctrl_chart_view)
    else $error("control limit warning without chart view");
endmodule

bind tse_monitor tse_monitor_props #(.VAL_W(VAL_W), .DISP_RANGE(DISP_RANGE)) u_props (
  .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .disp_value(disp_value), .disp_valid(disp_valid), .meas_req(meas_req), .err_evt(err_evt),
  .cancel_key(cancel_key), .ext_ack_pin(ext_ack_pin), .below_out(below_out), .above_out(above_out),
  .error_out(error_out), .sym(sym), .colour(colour), .err_shown_valid(err_shown_valid),
  .err_shown_code(err_shown_code), .ctrl_chart_view(ctrl_chart_view));

`default_nettype wire

// ==== verif/tse_auto_ctrl.sv ====
// Automation controller model on the switching connector
`default_nettype none

module tse_auto_ctrl (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ack_req,
  output logic      ext_ack_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold_q;  // Cycles left with the pin held high
  // Holds the acknowledge pin high for a few cycles per request
  always_ff @(posedge clk) begin
    if (reset) hold_q <= 3'h0;
    else if (ack_req) hold_q <= 3'h4;
    else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
  end
  assign ext_ack_pin = (hold_q != 3'h0);
endmodule

`default_nettype wire

// ==== verif/tse_monitor_tb.sv ====
// Self-checking testbench of the tolerance sorting and error monitor
`default_nettype none

module tse_monitor_tb;
  import tse_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk, reset, wr_en, rd_en, disp_valid, meas_req, cancel_key, ack_req, ext_ack_pin;
  logic [ADDR_W-1:0]  addr;
  logic [DATA_W-1:0]  wdata, rdata, rd_q;
  logic signed [39:0] disp_value;
  tse_err_evt_t       err_evt, ev;
  logic               below_out, above_out, error_out, err_shown_valid, ctrl_chart_view;
  tse_sort_t          sym;
  tse_colour_t        colour;
  logic [CAT_W-1:0]   err_shown_code;
  int                 errors, n_compared, cyc;
  int                 cat_of [12] = '{13, 6, 7, 10, 11, 8, 9, 3, 4, 2, 1, 0};  // Event bit to category

  tse_monitor #(.DISP_RANGE(1000), .REQ_GAP_NS(50)) u_dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .disp_value(disp_value), .disp_valid(disp_valid), .meas_req(meas_req), .err_evt(err_evt),
    .cancel_key(cancel_key), .ext_ack_pin(ext_ack_pin), .below_out(below_out), .above_out(above_out),
    .error_out(error_out), .sym(sym), .colour(colour), .err_shown_valid(err_shown_valid),
    .err_shown_code(err_shown_code), .ctrl_chart_view(ctrl_chart_view));
  tse_auto_ctrl u_auto (.clk(clk), .reset(reset), .ack_req(ack_req), .ext_ack_pin(ext_ack_pin));

  // Compares one value and counts the result
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rd_q = rdata;
  endtask
  // Sends one value and checks the sorting result
  task automatic sortv(logic signed [39:0] v, logic [2:0] s, logic b, logic a, tse_colour_t c);
    @(posedge clk);
    disp_value <= v;
    disp_valid <= 1'b1;
    @(posedge clk);
    disp_valid <= 1'b0;
    #1 check("sym", sym, s);
    check("below_out", below_out, b);
    check("above_out", above_out, a);
    check("colour", colour, c);
  endtask
  task automatic evt(tse_err_evt_t e);
    @(posedge clk);
    err_evt <= e;
    @(posedge clk);
    err_evt <= '0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Acknowledge by register, by key or by the controller model
  task automatic ack(int k);
    if (k == 0) wr(REG_ACK, 32'h0000_0000);
    else begin
      @(posedge clk);
      if (k == 1) cancel_key <= 1'b1;
      else ack_req <= 1'b1;
      @(posedge clk);
      cancel_key <= 1'b0;
      ack_req <= 1'b0;
    end
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic mreq(int gap);
    repeat (gap) @(posedge clk);
    meas_req <= 1'b1;
    @(posedge clk);
    meas_req <= 1'b0;
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cuts a hung run short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    {reset, wr_en, rd_en, disp_valid, meas_req, cancel_key, ack_req} = 7'h7f & 7'h40;
    addr = '0;
    wdata = '0;
    disp_value = '0;
    err_evt = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(REG_CTRL);
    check("ctrl", rd_q, 32'h0000_0000);
    check("colour", colour, COL_BLUE);
    $display("reset test done");
    wr(REG_LOWER, 32'hffff_fff6);
    wr(REG_UPPER, 32'h0000_0014);
    wr(REG_CTRL, 32'h0000_0003);
    sortv(-11, 3'b100, 1'b1, 1'b0, COL_RED);
    sortv(-10, 3'b010, 1'b0, 1'b0, COL_GREEN);
    sortv(20, 3'b010, 1'b0, 1'b0, COL_GREEN);
    sortv(21, 3'b001, 1'b0, 1'b1, COL_RED);
    rd(REG_SHOWN);
    check("shown_sym", rd_q[18:16], 3'b100);
    sortv(2000, 3'b001, 1'b0, 1'b1, COL_RED);
    rd(REG_ERRS);
    check("errs_overflow", rd_q, 32'h0000_0020);
    ack(2);
    check("shown_after_pin", err_shown_valid, 1'b0);
    wr(REG_LOWER, 32'h0000_000a);
    wr(REG_UPPER, 32'h0000_0005);
    sortv(7, 3'b111, 1'b1, 1'b1, COL_RED);
    wr(REG_CTRL, 32'h0000_0001);
    wr(REG_UPPER, 32'h0000_0014);
    sortv(-50, 3'b100, 1'b1, 1'b0, COL_BLUE);
    wr(REG_CTRL, 32'h0000_0000);
    sortv(-50, 3'b000, 1'b0, 1'b0, COL_BLUE);
    $display("sorting test done");
    for (int i = 0; i < 12; i++) begin
      ev = '0;
      ev[i] = 1'b1;
      evt(ev);
      rd(REG_ERRS);
      check("errs_cat", rd_q, 32'h0000_0001 << cat_of[i]);
      check("shown_code", err_shown_code, cat_of[i]);
      check("error_out", error_out, ENC_ERR_MASK[cat_of[i]]);
      check("chart_view", ctrl_chart_view, cat_of[i] == 13);
      ack(i % 2);
      check("cleared", err_shown_valid, 1'b0);
    end
    $display("category test done");
    ev = '0;
    ev.dsr_missing = 1'b1;
    evt(ev);
    evt(ev);
    ev = '0;
    ev.link_fault = 1'b1;
    evt(ev);
    check("newest_code", err_shown_code, CAT_LINK_FAULT);
    check("newest_errout", error_out, 1'b1);
    ack(1);
    check("prev_code", err_shown_code, CAT_DSR_MISSING);
    check("prev_errout", error_out, 1'b0);
    ack(0);
    check("one_per_cat", err_shown_valid, 1'b0);
    $display("stack test done");
    mreq(1);
    mreq(12);
    rd(REG_ERRS);
    check("rate_slow", rd_q, 32'h0000_0000);
    mreq(3);
    rd(REG_ERRS);
    check("rate_fast", rd_q, 32'h0000_1000);
    ack(0);
    $display("rate test done");
    complete_run();
  end
endmodule

`default_nettype wire
